// *** pkg/sadc_pkg.sv ***
// Functional notes
// - Start write begins conversion, clears done flag
// - Conversion completion sets the done flag
// - One conversion per start, no auto-restart
// - Start during conversion restarts it at once
// - Start trigger bit always reads zero
// - Done flag raises completion interrupt, vector four
// - Interrupt passes only while mask bit set
// - Power bit enables converter; zero powers down
// - Wait state never clears power bit
// - Reset stops conversion, control reads 40h, masked
// - Eight-bit successive approximation, clock divided twelve
// - Conversion lasts 60us at 8MHz: 70us target, per-bit ticks rounded down
// - Control at 0D1h: mask, done, start, power
// - Result at 0D0h, read-only eight-bit value
`default_nettype none
package sadc_pkg;
  localparam logic [7:0] SADC_ADDR_RESULT  = 8'hd0;
  localparam logic [7:0] SADC_ADDR_CONTROL = 8'hd1;
  localparam int         SADC_BIT_MASK     = 7;
  localparam int         SADC_BIT_DONE     = 6;
  localparam int         SADC_BIT_START    = 5;
  localparam int         SADC_BIT_POWER    = 4;
  localparam logic [7:0] SADC_CTRL_RESET   = 8'h40;
  localparam int         SADC_CLK_DIV      = 12;
  localparam int         SADC_CONV_TIME_NS = 70000;
  localparam int         SADC_OSC_REF_KHZ  = 8000;
  // Divided-clock cycles per conversion: 70us * 8MHz / 12, rounded down
  localparam int         SADC_CONV_TICKS   =
    (SADC_CONV_TIME_NS * SADC_OSC_REF_KHZ) / (1000000 * SADC_CLK_DIV);
  localparam int         SADC_DATA_W       = 8;
  typedef enum logic [0:0] {
    SADC_IDLE = 1'b0,
    SADC_CONV = 1'b1
  } sadc_state_t;
endpackage : sadc_pkg
`default_nettype wire

// *** hdl/sadc_ctrl.sv ***
`default_nettype none
module sadc_ctrl
  import sadc_pkg::*;
#(
  parameter int DIV   = SADC_CLK_DIV,
  parameter int TICKS = SADC_CONV_TICKS
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  // Processor data-space access
  input  wire logic [7:0]             cpu_addr,
  input  wire logic                   cpu_wr,
  input  wire logic [7:0]             cpu_wdata,
  output logic [7:0]                  cpu_rdata,
  // Processor state
  input  wire logic                   cpu_wait,
  // Analog comparator
  output logic [SADC_DATA_W-1:0]      dac_code,
  input  wire logic                   cmp_high,
  output logic                        converter_power,
  // Status
  output logic                        busy,
  output logic                        done_irq
);
  import sadc_pkg::*;

  localparam int STEP_W = $clog2(TICKS + 1);
  localparam int DIV_W  = $clog2(DIV + 1);
  localparam int BIT_W  = $clog2(SADC_DATA_W + 1);
  // Divided-clock ticks given to each bit decision
  localparam int PER_BIT = (TICKS / SADC_DATA_W) < 1 ? 1 : TICKS / SADC_DATA_W;

  typedef struct packed {
    sadc_state_t               state;
    logic                      done_irq_mask;
    logic                      done;
    logic                      power;
    logic [DIV_W-1:0]          div_cnt;
    logic [STEP_W-1:0]         tick_cnt;
    logic [BIT_W-1:0]          bit_idx;
    logic [SADC_DATA_W-1:0]    trial;
    logic [SADC_DATA_W-1:0]    result;
    logic [7:0]                rdata;
  } sadc_regs_t;

  sadc_regs_t r_reg;
  sadc_regs_t r_next;

  logic wr_ctrl;
  logic start_req;
  logic div_tick;

  always_comb begin
    wr_ctrl   = cpu_wr && (cpu_addr == SADC_ADDR_CONTROL);
    start_req = wr_ctrl && cpu_wdata[SADC_BIT_START];
    div_tick  = (r_reg.div_cnt == DIV_W'(DIV - 1));
    r_next    = r_reg;
    if (wr_ctrl) begin
      r_next.done_irq_mask = cpu_wdata[SADC_BIT_MASK];
      r_next.power         = cpu_wdata[SADC_BIT_POWER];
    end
    // cpu_wait deliberately ignored: power held
    r_next.div_cnt = div_tick ? '0 : r_reg.div_cnt + DIV_W'(1);
    unique case (r_reg.state)
      SADC_IDLE: begin
        // Stays idle until a new start write
      end
      SADC_CONV: begin
        if (div_tick) begin
          if (r_reg.tick_cnt == STEP_W'(PER_BIT - 1)) begin
            r_next.tick_cnt = '0;
            if (cmp_high) begin
              r_next.trial[r_reg.bit_idx[2:0]] = 1'b0;
            end
            if (r_reg.bit_idx == '0) begin
              r_next.state  = SADC_IDLE;
              r_next.done   = 1'b1;
              r_next.result = cmp_high ?
                (r_reg.trial & ~(SADC_DATA_W'(1))) : r_reg.trial;
            end else begin
              r_next.bit_idx = r_reg.bit_idx - BIT_W'(1);
              r_next.trial[r_reg.bit_idx[2:0] - 3'd1] = 1'b1;
            end
          end else begin
            r_next.tick_cnt = r_reg.tick_cnt + STEP_W'(1);
          end
        end
        if (!r_reg.power) begin
          r_next.state = SADC_IDLE;
        end
      end
    endcase
    // Start, or restart over a running conversion
    if (start_req && (wr_ctrl ? cpu_wdata[SADC_BIT_POWER] : r_reg.power)) begin
      r_next.state    = SADC_CONV;
      r_next.done     = 1'b0;
      r_next.tick_cnt = '0;
      r_next.div_cnt  = '0;
      r_next.bit_idx  = BIT_W'(SADC_DATA_W - 1);
      r_next.trial    = {1'b1, {(SADC_DATA_W-1){1'b0}}};
    end else if (start_req) begin
      r_next.done = 1'b0;
    end
    // Registered read data; start bit reads zero
    if (cpu_addr == SADC_ADDR_CONTROL) begin
      r_next.rdata = {r_next.done_irq_mask, r_next.done, 1'b0, r_next.power, 4'h0};
    end else if (cpu_addr == SADC_ADDR_RESULT) begin
      r_next.rdata = r_next.result;
    end else begin
      r_next.rdata = 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // Control reads 40h, no conversion, masked
      r_reg.state         <= SADC_IDLE;
      r_reg.done_irq_mask <= SADC_CTRL_RESET[SADC_BIT_MASK];
      r_reg.done          <= SADC_CTRL_RESET[SADC_BIT_DONE];
      r_reg.power         <= SADC_CTRL_RESET[SADC_BIT_POWER];
      r_reg.div_cnt       <= '0;
      r_reg.tick_cnt      <= '0;
      r_reg.bit_idx       <= '0;
      r_reg.trial         <= '0;
      r_reg.result        <= '0;
      r_reg.rdata         <= 8'h00;
    end else begin
      r_reg <= r_next;
    end
  end

  assign cpu_rdata       = r_reg.rdata;
  assign dac_code        = r_reg.trial;
  assign converter_power = r_reg.power;
  assign busy            = (r_reg.state == SADC_CONV);
  assign done_irq        = r_reg.done && r_reg.done_irq_mask;
endmodule // sadc_ctrl
`default_nettype wire

// *** sim/sadc_ctrl_properties.sv ***
`default_nettype none
module sadc_ctrl_properties #(
  parameter int DIV   = 12,
  parameter int TICKS = 46
) (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic [7:0] cpu_addr,
  input wire logic       cpu_wr,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic       cpu_wait,
  input wire logic [7:0] dac_code,
  input wire logic       converter_power,
  input wire logic       busy,
  input wire logic       done_irq
);
  localparam int LEN = DIV * (TICKS / 8) * 8;
  logic w;
  logic go;
  int   n;
  assign w = cpu_wr && cpu_addr == 8'hd1;
  assign go = w && cpu_wdata[5] && cpu_wdata[4];
  always_ff @(posedge clk_sys) n <= (go || !busy) ? 0 : n + 1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_go; go; endsequence
  sequence s_end; $fell(busy) && !$past(w) && !$past(sys_rst); endsequence
  property p_start; s_go |=> busy && !done_irq; endproperty
  a_start: assert property (p_start) else $error("start");
  property p_restart; busy ##0 s_go |=> busy && dac_code == 8'h80; endproperty
  a_restart: assert property (p_restart) else $error("restart");
  property p_once; !busy && !go |=> !busy; endproperty
  a_once: assert property (p_once) else $error("self start");
  property p_time; s_end |-> n >= LEN && n <= LEN + DIV + 4; endproperty
  a_time: assert property (p_time) else $error("length");
  property p_rd; $past(cpu_addr) == 8'hd1 |-> cpu_rdata[5] == 0 && cpu_rdata[3:0] == 0; endproperty
  a_rd: assert property (p_rd) else $error("read bits");
  property p_mask; w && !cpu_wdata[7] |=> !done_irq; endproperty
  a_mask: assert property (p_mask) else $error("mask");
  property p_pwr; w && !cpu_wdata[4] |=> !busy && !converter_power; endproperty
  a_pwr: assert property (p_pwr) else $error("power");
  property p_wait; cpu_wait && !w |=> $stable(converter_power); endproperty
  a_wait: assert property (p_wait) else $error("wait");
  property p_rst;
    disable iff (1'b0) sys_rst |=> !busy && !done_irq && !converter_power && dac_code == 0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset");
endmodule // sadc_ctrl_properties
bind sadc_ctrl sadc_ctrl_properties #(.DIV(DIV), .TICKS(TICKS)) u_props (.*);
`default_nettype wire

// *** sim/tb_sadc_ctrl.sv ***
`default_nettype none
module tb_sadc_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys = 0, sys_rst = 1, cpu_wr = 0, cpu_wait = 0, cmp_high = 0;
  logic       rv = 0, rv2 = 0, converter_power, busy, done_irq;
  logic [7:0] cpu_addr = 0, cpu_wdata = 0, vin = 0, cpu_rdata, dac_code;
  logic [8:0] q[$];
  int         failures = 0, comparisons = 0, i, k;
  initial forever #25 clk_sys = ~clk_sys;
  sadc_ctrl #(.TICKS(8)) u_sadc_ctrl (
    .clk_sys         (clk_sys),
    .sys_rst         (sys_rst),
    .cpu_addr        (cpu_addr),
    .cpu_wr          (cpu_wr),
    .cpu_wdata       (cpu_wdata),
    .cpu_rdata       (cpu_rdata),
    .cpu_wait        (cpu_wait),
    .dac_code        (dac_code),
    .cmp_high        (cmp_high),
    .converter_power (converter_power),
    .busy            (busy),
    .done_irq        (done_irq)
  );
  // Comparator model on one analog input, read scoreboard
  always @(posedge clk_sys) begin
    cmp_high <= dac_code > vin;
    rv2 <= rv;
  end
  always @(negedge clk_sys) if (rv2) begin
    comparisons++;
    if (q[0] !== {done_irq, cpu_rdata}) begin
      failures++;
      $display("mismatch irq_rdata exp %h got %h", q[0], {done_irq, cpu_rdata});
    end
    void'(q.pop_front());
  end
  task automatic wr(input logic [7:0] d);
    cpu_wr <= 1;
    cpu_addr <= 8'hd1;
    cpu_wdata <= d;
    @(posedge clk_sys) cpu_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    cpu_addr <= a;
    rv <= 1;
    q.push_back(e);
    @(posedge clk_sys) rv <= 0;
  endtask
  task automatic print_verdict();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    void'($urandom(37));
    repeat (2) @(posedge clk_sys);
    sys_rst <= 0;
    rd(8'hd1, 9'h040);
    wr(8'h90);
    rd(8'hd1, 9'h1d0);
    for (i = 0; i < 4; i++) begin
      vin <= (i == 3) ? 8'hff : 8'($urandom);
      wr(8'hb0);
      rd(8'hd1, 9'h090);
      if (i == 1) begin
        repeat (30) @(posedge clk_sys);
        wr(8'hb0);
        vin <= ~vin;
      end
      for (k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clk_sys);
      if (k == 200) begin
        failures++;
        break;
      end
      rd(8'hd1, 9'h1d0);
      rd(8'hd0, {1'b1, vin});
    end
    cpu_wait <= 1;
    wr(8'h10);
    rd(8'hd1, 9'h050);
    repeat (20) @(posedge clk_sys);
    rd(8'hd1, 9'h050);
    wr(8'h20);
    rd(8'hd1, 9'h000);
    rd(8'h55, 9'h000);
    wr(8'hb0);
    sys_rst <= 1;
    @(posedge clk_sys) sys_rst <= 0;
    rd(8'hd1, 9'h040);
    print_verdict();
  end
endmodule // tb_sadc_ctrl
`default_nettype wire
